// ===== dv/copro_core_model.sv
/*
  Processor-core model that issues coprocessor instructions to the issue port.
  Assumes it is called between falling edges and the clock runs throughout.
*/
`timescale 1ns/1ps
module copro_core_model
  import copro_pkg::*;
(
  input wire logic clock,
  input wire logic busy,
  input wire logic stall,
  input wire logic destination_we,
  input wire logic [31:0] destination_reg,
  input wire logic reserved_operand,
  output logic issue_valid,
  output logic [2:0] result_sel,
  output logic [2:0] func_code,
  output logic [2:0] operand_format_field,
  output logic [31:0] first_source_reg,
  output logic [31:0] second_source_reg
);
  // ---------------------------------------------------------------
  // Answer captured for the last accepted instruction
  // ---------------------------------------------------------------
  logic got_we;
  logic got_rsv;
  logic [31:0] got_word;
  int stalls;

  // Quiet request lines at time zero
  initial begin
    issue_valid = 1'b0;
    result_sel = 3'h7;
    func_code = 3'h4;
    operand_format_field = 3'h0;
    first_source_reg = 32'h0;
    second_source_reg = 32'h0;
  end

  // Holds the whole instruction until an edge where busy was low
  task automatic issue(input logic [2:0] sel, input logic [2:0] fn, input logic [2:0] fmt,
                       input logic [31:0] hi, input logic [31:0] lo);
    logic free;
    issue_valid = 1'b1;
    result_sel = sel;
    func_code = fn;
    operand_format_field = fmt;
    first_source_reg = hi;
    second_source_reg = lo;
    stalls = 0;
    free = 1'b0;
    while (!free) begin
      // Busy is registered, so it is stable when read here
      free = (busy === 1'b0);
      @(negedge clock);
      if (!free && stall === 1'b1) stalls++;
    end
    got_we = destination_we;
    got_rsv = reserved_operand;
    got_word = destination_reg;
  endtask : issue

  // Drops the request; operands flip so a stale word is never reused
  task automatic idle();
    issue_valid = 1'b0;
    first_source_reg = ~first_source_reg;
    second_source_reg = ~second_source_reg;
    @(negedge clock);
  endtask : idle
endmodule : copro_core_model

// ===== dv/copro_issue_tb_top.sv
/*
  Self-checking bench for the coprocessor issue port.
  Assumes the core model drives requests at falling edges.
*/
`timescale 1ns/1ps
module copro_issue_tb_top
  import copro_pkg::*;
;
  // ---------------------------------------------------------------
  // Signals and instances
  // ---------------------------------------------------------------
  logic clock;
  logic sys_rst;
  logic issue_valid, stall, destination_we, reserved_operand, busy, acc_sign;
  logic [2:0] result_sel, func_code, operand_format_field;
  logic [31:0] first_source_reg, second_source_reg, destination_reg;
  logic [15:0] acc_exp;
  logic [63:0] acc_frac;
  int num_errors = 0;
  int cmp_count = 0;
  int cycles = 0;

  copro_issue u_copro_issue (.clock(clock), .sys_rst(sys_rst), .issue_valid(issue_valid),
    .result_sel(result_sel), .func_code(func_code),
    .operand_format_field(operand_format_field), .first_source_reg(first_source_reg),
    .second_source_reg(second_source_reg), .stall(stall), .destination_we(destination_we),
    .destination_reg(destination_reg), .reserved_operand(reserved_operand), .busy(busy),
    .acc_sign(acc_sign), .acc_exp(acc_exp), .acc_frac(acc_frac));

  copro_core_model u_copro_core_model (.clock(clock), .busy(busy), .stall(stall),
    .destination_we(destination_we), .destination_reg(destination_reg),
    .reserved_operand(reserved_operand), .issue_valid(issue_valid), .result_sel(result_sel),
    .func_code(func_code), .operand_format_field(operand_format_field),
    .first_source_reg(first_source_reg), .second_source_reg(second_source_reg));

  // 125 MHz clock
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  // Cuts a hang short; the divide is the longest wait at about 33 cycles
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      end_of_test();
    end
  end

  // ---------------------------------------------------------------
  // Shared helpers
  // ---------------------------------------------------------------
  task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic go(input logic [2:0] sel, input logic [2:0] fn, input logic [2:0] fmt,
                    input logic [31:0] hi, input logic [31:0] lo);
    u_copro_core_model.issue(sel, fn, fmt, hi, lo);
  endtask : go

  // Write strobe and returned word of the last instruction
  function automatic logic [63:0] res_word();
    return {31'h0, u_copro_core_model.got_we, u_copro_core_model.got_word};
  endfunction : res_word

  task automatic acc_is(input logic s, input logic [15:0] e, input logic [63:0] f);
    check("acc_sign", {63'h0, s}, {63'h0, acc_sign});
    check("acc_exp", {48'h0, e}, {48'h0, acc_exp});
    check("acc_frac", f, acc_frac);
  endtask : acc_is

  task automatic end_of_test();
    if (num_errors == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_of_test

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    acc_is(1'b0, 16'h0, 64'h0);
    check("busy", 64'h0, {63'h0, busy});
  endtask : t_reset

  // Back-to-back loads: each returns the accumulator as it was before it
  task automatic t_int_load();
    go(res_frac_high, func_load, fmt_int, 32'h8000_0001, 32'h0000_0002);
    acc_is(1'b1, 16'h0, 64'h8000_0001_0000_0002);
    go(res_frac_high, func_load, fmt_int, 32'h1234_5678, 32'h9abc_def0);
    check("result", {32'h1, 32'h8000_0001}, res_word());
    go(res_frac_low, func_misc, fmt_int, 32'h0, 32'h0);
    check("result", {32'h1, 32'h9abc_def0}, res_word());
    acc_is(1'b0, 16'h0, 64'h1234_5678_9abc_def0);
  endtask : t_int_load

  // Carries and borrows cross the word boundary
  task automatic t_int_arith();
    go(res_null, func_load, fmt_int, 32'h0, 32'hffff_ffff);
    go(res_null, func_add, fmt_int, 32'h0, 32'h1);
    check("acc_frac", 64'h1_0000_0000, acc_frac);
    go(res_null, func_sub, fmt_int, 32'h0, 32'h2);
    check("acc_frac", 64'hffff_fffe, acc_frac);
    go(res_null, func_rsub, fmt_int, 32'h0, 32'h0);
    check("acc_frac", 64'hffff_ffff_0000_0002, acc_frac);
  endtask : t_int_arith

  // Negative high word times three, read back while still busy
  task automatic t_mul();
    go(res_null, func_load, fmt_int, 32'hffff_fffe, 32'h0);
    go(res_null, func_mul, fmt_int, 32'h3, 32'h0);
    check("busy", 64'h1, {63'h0, busy});
    go(res_frac_low, func_misc, fmt_int, 32'h0, 32'h0);
    check("stalled", 64'h1, {63'h0, u_copro_core_model.stalls > 0});
    check("result", {32'h1, 32'hffff_fffa}, res_word());
    check("acc_frac", 64'hffff_ffff_ffff_fffa, acc_frac);
  endtask : t_mul

  // Divisor nonzero and above the high word, second source zero, odd quotient
  task automatic t_div();
    go(res_null, func_load, fmt_int, 32'h0, 32'd106);
    go(res_null, func_div, fmt_int, 32'd7, 32'h0);
    go(res_frac_low, func_misc, fmt_int, 32'h0, 32'h0);
    check("stalled", 64'h1, {63'h0, u_copro_core_model.stalls > 16});
    check("result", {32'h1, 32'd15}, res_word());
    check("acc_frac", {32'd1, 32'd15}, acc_frac);
    go(res_null, func_load, fmt_int, 32'd7, 32'h0);
    go(res_null, func_rdiv, fmt_int, 32'h0, 32'd106);
    go(res_frac_high, func_misc, fmt_int, 32'h0, 32'h0);
    check("result", {32'h1, 32'd1}, res_word());
    check("acc_frac", {32'd1, 32'd15}, acc_frac);
  endtask : t_div

  // Float loads in every input format, reserved and zero operands
  task automatic t_float();
    go(res_null, func_load, fmt_single, 32'h40c0_0000, 32'h0);
    acc_is(1'b0, 16'h0001, 64'h6000_0000_0000_0000);
    go(res_null, func_load, fmt_single, 32'hbf80_0000, 32'h0);
    acc_is(1'b1, 16'hffff, 64'h4000_0000_0000_0000);
    go(res_null, func_load, fmt_single_in_double_round, 32'h40c0_0000, 32'h0);
    acc_is(1'b1, 16'hffff, 64'h4000_0000_0000_0000);
    go(res_null, func_load, fmt_single, 32'h8000_0000, 32'h0);
    check("reserved", 64'h1, {63'h0, u_copro_core_model.got_rsv});
    acc_is(1'b1, 16'hffff, 64'h4000_0000_0000_0000);
    go(res_null, func_load, fmt_single, 32'h0, 32'h0);
    acc_is(1'b0, 16'h0, 64'h0);
    go(res_null, func_load, fmt_double, 32'h3ff8_0000, 32'h0000_0001);
    acc_is(1'b0, 16'hffff, 64'h6000_0000_0000_0400);
    go(res_null, func_load, fmt_double_in_single_round, 32'h4000_0000, 32'h1000_0000);
    acc_is(1'b0, 16'h0, 64'h4000_0080_0000_0000);
    go(res_null, func_load, fmt_double, 32'h0, 32'h0);
    acc_is(1'b0, 16'h0, 64'h0);
  endtask : t_float

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    sys_rst = 1'b1;
    repeat (3) @(negedge clock);
    sys_rst = 1'b0;
    t_reset();
    t_int_load();
    u_copro_core_model.idle();
    t_int_arith();
    u_copro_core_model.idle();
    t_mul();
    u_copro_core_model.idle();
    t_div();
    u_copro_core_model.idle();
    t_float();
    u_copro_core_model.idle();
    end_of_test();
  end
endmodule : copro_issue_tb_top

// ===== pkg/acc_if.sv
/*
  Interface carrying the divide start, operands, busy/done and results between the issue port and its
  long-latency engine.  Assumes both ends sit on the same clock.
*/
`timescale 1ns/1ps
interface acc_if;
  logic start;
  logic is_div;
  logic [63:0] dividend;
  logic [31:0] divisor;
  logic busy;
  logic done;
  logic [31:0] quotient;
  logic [31:0] remainder;
  modport issue (output start, is_div, dividend, divisor, input busy, done, quotient, remainder);
  modport engine (input start, is_div, dividend, divisor, output busy, done, quotient, remainder);
endinterface : acc_if

// ===== pkg/copro_pkg.sv
/*
  Shared constants and types for the arithmetic coprocessor issue port.
  Assumes a single 125 MHz processor clock and a synchronous active-high reset.
*/
package copro_pkg;

  // ---------------------------------------------------------------
  // Instruction field codes
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    func_load = 3'h0,
    func_add = 3'h1,
    func_sub = 3'h2,
    func_rsub = 3'h3,
    func_misc = 3'h4,
    func_mul = 3'h5,
    func_div = 3'h6,
    func_rdiv = 3'h7
  } func_t;

  typedef enum logic [2:0] {
    fmt_int = 3'h0,
    fmt_rsv1 = 3'h1,
    fmt_rsv2 = 3'h2,
    fmt_rsv3 = 3'h3,
    fmt_single = 3'h4,
    fmt_single_in_double_round = 3'h5,
    fmt_double_in_single_round = 3'h6,
    fmt_double = 3'h7
  } fmt_t;

  // ---------------------------------------------------------------
  // External and internal number layouts
  // ---------------------------------------------------------------
  localparam int single_exp_lsb = 23;
  localparam int single_exp_w = 8;
  localparam int single_frac_w = 23;
  localparam int double_exp_lsb = 52;
  localparam int double_exp_w = 11;
  localparam int double_frac_w = 52;
  localparam logic [15:0] single_bias = 16'h0080;
  localparam logic [15:0] double_bias = 16'h0400;
  localparam int acc_exp_w = 16;
  localparam int acc_frac_w = 64;

  // Result selector codes
  localparam logic [2:0] res_frac_high = 3'h0;
  localparam logic [2:0] res_frac_low = 3'h1;
  localparam logic [2:0] res_single = 3'h2;
  localparam logic [2:0] res_double_high = 3'h3;
  localparam logic [2:0] res_double_low = 3'h4;
  localparam logic [2:0] res_exponent = 3'h5;
  localparam logic [2:0] res_sign = 3'h6;
  localparam logic [2:0] res_null = 3'h7;

  // Reset values and timing
  localparam logic [15:0] acc_exp_reset = 16'h0000;
  localparam logic [63:0] acc_frac_reset = 64'h0;
  localparam int div_cycles = 32;
  localparam logic [5:0] div_count_init = 6'h20;
  localparam logic [5:0] mul_count_init = 6'h02;

endpackage : copro_pkg

// ===== src/copro_divider.sv
/*
  Unsigned 64 by 32 restoring divider, one quotient bit per clock.
  Assumes the caller only starts it while idle; dividend and divisor are latched at start.
*/
`timescale 1ns/1ps
module copro_divider
  import copro_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  acc_if.engine port
);

  logic [5:0] count;
  logic [32:0] part;
  logic [31:0] quot;
  logic [31:0] low;
  logic [32:0] trial;
  logic [31:0] dvsr;

  // Divisor is latched at start; the core moves on to new operands meanwhile
  assign trial = {part[31:0], low[31]} - {1'b0, dvsr};

  // ---------------------------------------------------------------
  // Iteration; caller guarantees high dividend below divisor
  // ---------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      count <= 6'h00;
      part <= 33'h0;
      quot <= 32'h0;
      low <= 32'h0;
      dvsr <= 32'h0;
      port.done <= 1'b0;
    end else begin
      port.done <= 1'b0;
      if (port.start && count == 6'h00) begin
        count <= div_count_init;
        part <= {1'b0, port.dividend[63:32]};
        low <= port.dividend[31:0];
        dvsr <= port.divisor;
        quot <= 32'h0;
      end else if (count != 6'h00) begin
        if (!trial[32]) begin
          part <= trial;
        end else begin
          part <= {part[31:0], low[31]};
        end
        quot <= {quot[30:0], ~trial[32]};
        low <= {low[30:0], 1'b0};
        count <= count - 6'h01;
        port.done <= (count == 6'h01);
      end
    end
  end

  assign port.busy = (count != 6'h00);
  assign port.quotient = quot;
  assign port.remainder = part[31:0];

endmodule : copro_divider

// ===== src/copro_issue.sv
/*
  Coprocessor issue port: returns part of the accumulator to the
  destination register and starts the next function on the source pair.
  Assumes the core holds the instruction stable while stall is high and
  that misc functions are handled elsewhere (treated here as no change).
*/
`timescale 1ns/1ps
module copro_issue
  import copro_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic issue_valid,
  input wire logic [2:0] result_sel,
  input wire logic [2:0] func_code,
  input wire logic [2:0] operand_format_field,
  input wire logic [31:0] first_source_reg,
  input wire logic [31:0] second_source_reg,
  output logic stall,
  output logic destination_we,
  output logic [31:0] destination_reg,
  output logic reserved_operand,
  output logic busy,
  output logic acc_sign,
  output logic [15:0] acc_exp,
  output logic [63:0] acc_frac
);

  // ---------------------------------------------------------------
  // Decode and operand unpacking
  // ---------------------------------------------------------------
  acc_if div_port ();
  func_t func;
  fmt_t fmt;
  logic [63:0] operand;
  logic is_float;
  logic in_double;
  logic round_single;
  logic op_zero;
  logic op_reserved;
  logic op_sign;
  logic [15:0] op_exp;
  logic [63:0] op_frac;
  logic accept;
  logic single_in_double_round;
  logic double_in_single_round;
  logic [1:0] mul_count;
  logic pend_div;
  logic pend_rdiv;
  logic [63:0] mul_prod;

  assign func = func_t'(func_code);
  assign fmt = fmt_t'(operand_format_field);
  assign operand = {first_source_reg, second_source_reg};
  assign is_float = operand_format_field[2];
  assign in_double = operand_format_field[1];
  assign round_single = !operand_format_field[0];
  assign single_in_double_round = (fmt == fmt_single_in_double_round);
  assign double_in_single_round = (fmt == fmt_double_in_single_round);
  // Stall while engine busy; hazard of overwriting a running result
  assign accept = issue_valid && !busy;

  // Unbias exponent after zero extension to 16 bits
  function automatic logic [15:0] unbias(input logic [10:0] e, input logic [15:0] bias);
    unbias = {5'h00, e} - bias;
  endfunction : unbias

  // Unpack external floating format into internal fields
  always_comb begin
    op_sign = first_source_reg[31];
    if (in_double) begin
      op_zero = (operand[62:52] == 11'h000);
      op_exp = unbias(operand[62:52], double_bias);
      op_frac = {2'b01, operand[51:0], 10'h000};
    end else begin
      op_zero = (first_source_reg[30:23] == 8'h00);
      op_exp = unbias({3'h0, first_source_reg[30:23]}, single_bias);
      op_frac = {2'b01, first_source_reg[22:0], 39'h0};
    end
    // Zero exponent with sign set is reserved, otherwise zero
    op_reserved = is_float && op_zero && op_sign;
  end

  // ---------------------------------------------------------------
  // Result selection to the destination register
  // ---------------------------------------------------------------
  function automatic logic [31:0] pick_result(input logic [2:0] sel, input logic s,
                                              input logic [15:0] e, input logic [63:0] f);
    logic [7:0] se;
    logic [10:0] de;
    se = 8'(e + single_bias);
    de = 11'(e + double_bias);
    unique case (sel)
      res_frac_high: pick_result = f[63:32];
      res_frac_low: pick_result = f[31:0];
      res_single: pick_result = {s, se, f[61:39]};
      res_double_high: pick_result = {s, de, f[61:42]};
      res_double_low: pick_result = f[41:10];
      res_exponent: pick_result = {{16{e[15]}}, e};
      res_sign: pick_result = {s, 31'h0};
      res_null: pick_result = 32'h0;
    endcase
  endfunction : pick_result

  // Result and operand hand-off share the accepting edge
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      destination_we <= 1'b0;
      destination_reg <= 32'h0;
    end else begin
      destination_we <= accept;
      if (accept) begin
        destination_reg <= pick_result(result_sel, acc_sign, acc_exp, acc_frac);
      end
    end
  end

  // Stall flag mirrors engine activity while the core holds a request
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      stall <= 1'b0;
      reserved_operand <= 1'b0;
    end else begin
      stall <= issue_valid && busy;
      reserved_operand <= accept && op_reserved;
    end
  end

  // ---------------------------------------------------------------
  // Multi-cycle engines: multiply counter and divider
  // ---------------------------------------------------------------
  copro_divider divider (
    .clock(clock),
    .sys_rst(sys_rst),
    .port(div_port.engine)
  );

  logic fp_start;
  logic [63:0] round_in;
  logic [15:0] round_exp_in;
  logic [63:0] rounded_frac;
  logic [15:0] rounded_exp;

  copro_rounder rounder (
    .frac_in(round_in),
    .exp_in(round_exp_in),
    .to_single(round_single),
    .frac_out(rounded_frac),
    .exp_out(rounded_exp)
  );

  assign fp_start = accept && !op_reserved;
  // Both factors sign-extended first so the full 64-bit product is formed
  assign mul_prod = $signed({{32{first_source_reg[31]}}, first_source_reg})
                    * $signed({{32{acc_frac[63]}}, acc_frac[63:32]});
  // Divide takes AC dividend; reverse divide takes operand, software zeroes high
  assign div_port.start = fp_start && !is_float && (func == func_div || func == func_rdiv);
  assign div_port.is_div = (func == func_div);
  assign div_port.dividend = (func == func_div) ? acc_frac : operand;
  assign div_port.divisor = (func == func_div) ? first_source_reg : acc_frac[63:32];

  // Busy covers divider run and the multiply latency
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      busy <= 1'b0;
      mul_count <= 2'h0;
    end else begin
      if (fp_start && !is_float && func == func_mul) begin
        mul_count <= 2'(mul_count_init);
      end else if (mul_count != 2'h0) begin
        mul_count <= mul_count - 2'h1;
      end
      busy <= div_port.start || (div_port.busy && !div_port.done)
              || (fp_start && !is_float && func == func_mul) || mul_count > 2'h1;
    end
  end

  // ---------------------------------------------------------------
  // Accumulator update
  // ---------------------------------------------------------------
  // Floating add/mul/div are not modelled and leave the accumulator unchanged; only a nonzero float load not in fmt_single_in_double_round takes the rounded operand
  assign round_in = op_frac;
  assign round_exp_in = op_exp;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      acc_sign <= 1'b0;
      acc_exp <= acc_exp_reset;
      acc_frac <= acc_frac_reset;
      pend_div <= 1'b0;
      pend_rdiv <= 1'b0;
    end else begin
      if (div_port.start) begin
        pend_div <= div_port.is_div;
        pend_rdiv <= !div_port.is_div;
      end
      if (div_port.done) begin
        acc_frac <= {div_port.remainder, div_port.quotient};
        pend_div <= 1'b0;
        pend_rdiv <= 1'b0;
      end else if (fp_start) begin
        unique case (func)
          func_load: begin
            if (!is_float) begin
              acc_frac <= operand;
              acc_sign <= first_source_reg[31];
            end else if (single_in_double_round) begin
              acc_frac <= acc_frac;
            end else if (op_zero) begin
              acc_sign <= 1'b0;
              acc_exp <= 16'h0000;
              acc_frac <= 64'h0;
            end else begin
              acc_sign <= op_sign;
              acc_exp <= rounded_exp;
              acc_frac <= rounded_frac;
            end
          end
          func_add: if (!is_float) acc_frac <= acc_frac + operand;
          func_sub: if (!is_float) acc_frac <= acc_frac - operand;
          func_rsub: if (!is_float) acc_frac <= operand - acc_frac;
          func_mul: if (!is_float) acc_frac <= mul_prod;
          default: acc_frac <= acc_frac;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  a_stall_when_busy: assert property (@(posedge clock) disable iff (sys_rst)
    issue_valid && busy |=> stall && !destination_we)
    else $error("Issue accepted while busy");
  a_write_on_accept: assert property (@(posedge clock) disable iff (sys_rst)
    accept |=> destination_we && destination_reg ==
      pick_result($past(result_sel), $past(acc_sign), $past(acc_exp), $past(acc_frac)))
    else $error("Destination not written from old accumulator");
  a_int_load: assert property (@(posedge clock) disable iff (sys_rst)
    fp_start && func == func_load && !is_float && !div_port.done
    |=> acc_frac == $past(operand) && acc_exp == $past(acc_exp))
    else $error("Integer load wrong");
  a_zero_load: assert property (@(posedge clock) disable iff (sys_rst)
    fp_start && func == func_load && is_float && !single_in_double_round && op_zero
    && !div_port.done |=> acc_frac == 64'h0 && acc_exp == 16'h0 && !acc_sign)
    else $error("Zero load did not clear accumulator");
  a_int_add: assert property (@(posedge clock) disable iff (sys_rst)
    fp_start && func == func_add && !is_float && !div_port.done
    |=> acc_frac == $past(acc_frac) + $past(operand))
    else $error("Integer add wrong");
  a_mul_busy: assert property (@(posedge clock) disable iff (sys_rst)
    fp_start && func == func_mul && !is_float |=> busy [*2])
    else $error("Multiply busy too short");
  a_div_result: assert property (@(posedge clock) disable iff (sys_rst)
    div_port.start && div_port.is_div |-> ##[1:40] div_port.done)
    else $error("Divide did not finish");
  a_reserved_flag: assert property (@(posedge clock) disable iff (sys_rst)
    accept && is_float && op_zero && op_sign |=> reserved_operand)
    else $error("Reserved operand missed");

endmodule : copro_issue

// ===== src/copro_rounder.sv
/*
  Rounds an internal fraction to single or double precision by
  round-to-nearest on the bit below the kept field.  Pure combinational.
  Assumes the fraction is normalised with the leading one in bit 62.
*/
`timescale 1ns/1ps
module copro_rounder
  import copro_pkg::*;
(
  input wire logic [63:0] frac_in,
  input wire logic [15:0] exp_in,
  input wire logic to_single,
  output logic [63:0] frac_out,
  output logic [15:0] exp_out
);

  logic [64:0] sum;
  logic [63:0] keep_mask;
  logic [63:0] half;

  // Keep the hidden bit plus 23 or 52 fraction bits below it
  always_comb begin
    keep_mask = to_single ? ~((64'h1 << (62 - single_frac_w)) - 64'h1)
                          : ~((64'h1 << (62 - double_frac_w)) - 64'h1);
    half = to_single ? (64'h1 << (61 - single_frac_w)) : (64'h1 << (61 - double_frac_w));
    sum = {1'b0, frac_in} + {1'b0, half};
    if (sum[63]) begin
      // Carry out of the hidden bit renormalises by one place
      frac_out = {1'b0, sum[63:1]} & keep_mask;
      exp_out = exp_in + 16'h0001;
    end else begin
      frac_out = sum[63:0] & keep_mask;
      exp_out = exp_in;
    end
  end

endmodule : copro_rounder
